/* File: design/boot_loader_consts.svh */
// Constants for the serial bootstrap loader block.
`ifndef BOOT_LOADER_CONSTS_SVH
`define BOOT_LOADER_CONSTS_SVH
`define CLK_MHZ          125
`define INIT_TIME_US     1000
`define INIT_CYCLES      (`INIT_TIME_US * `CLK_MHZ + 1)
`define TX_DELAY_US      1300
`define TX_DELAY_CYCLES  (`TX_DELAY_US * `CLK_MHZ)
`define ZERO_BYTE_BITS   9
`define CODE_BYTES       32
`define LOAD_BASE_ADDR   24'h00fa40
// The acknowledge value is arbitrary; it only has to be fixed for one device.
`define ACK_BYTE_VALUE   8'h3c
`define FIFO_DEPTH       4
`define FIFO_WIDTH       8
`define IDX_W            5
`define CNT_W            24
`endif

/* File: design/boot_loader_pkg.sv */
// Types shared by the serial bootstrap loader files.
package boot_loader_pkg;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } load_write_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_INIT, ST_WAIT_START, ST_MEASURE, ST_WAIT_STOP, ST_TX_DELAY,
    ST_SEND_ACK, ST_LOAD, ST_RUN
  } boot_state_t;
endpackage

/* File: design/byte_fifo.sv */
// Small valid/ready FIFO that buffers received code bytes.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              do_wr = wr_valid_in & wr_ready_out;
  wire              do_rd = rd_valid_out & rd_ready_in;

  assign wr_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_ff != '0);
  assign rd_data_out  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

/* File: design/boot_loader.sv */
// Serial bootstrap entry: autobaud on a zero byte, acknowledge, load 32 bytes, run.
`timescale 1ns/1ps
`default_nettype none
`include "boot_loader_consts.svh"
module boot_loader
  import boot_loader_pkg::*;
#(
  parameter int INIT_CYCLES     = `INIT_CYCLES,
  parameter int TX_DELAY_CYCLES = `TX_DELAY_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sw_reset_in,
  input  wire logic        boot_strap_pin_in,
  input  wire logic        serial_receive_line_in,
  output logic             serial_transmit_line_out,
  output logic             serial_transmit_oe_out,
  output logic             bootstrap_loader_mode_out,
  output logic [15:0]      baud_factor_out,
  output load_write_t      mem_write_out,
  output logic             mem_write_valid_out,
  output logic             branch_out,
  output logic [23:0]      branch_addr_out
);
  // Pin inputs pass two flip-flops; the first stage feeds only the second.
  logic rx_meta_ff, rx_ff, strap_meta_ff, strap_ff, rx_prev_ff;
  logic rst_seen_ff;
  always_ff @(posedge clk_in) begin
    rx_meta_ff    <= serial_receive_line_in;
    rx_ff         <= rx_meta_ff;
    strap_meta_ff <= boot_strap_pin_in;
    strap_ff      <= strap_meta_ff;
    rx_prev_ff    <= rx_ff;
  end
  wire rx_fall = rx_prev_ff & ~rx_ff;
  wire rx_rise = ~rx_prev_ff & rx_ff;

  boot_state_t      state_ff, nxt_state;
  logic             mode_ff;
  logic [`CNT_W-1:0] cnt_ff;
  logic [15:0]      baud_ff;
  logic             oe_ff, tx_ff;
  logic [`IDX_W:0]  rx_count_ff;
  logic [`IDX_W-1:0] wr_idx_ff;
  logic [15:0]      bit_cnt_ff;
  logic [3:0]       bit_idx_ff;
  logic [9:0]       shift_ff;
  logic             rx_busy_ff;
  logic [7:0]       rx_data_ff;
  logic             rx_done_ff;
  logic             branch_ff;
  load_write_t      mem_wr_ff;
  logic             mem_wr_v_ff;

  wire cnt_zero = (cnt_ff == '0);
  wire bit_tick = (bit_cnt_ff == 16'h0000);
  // Half a bit; the receiver first samples one and a half bits after the start edge, mid data bit 0.
  wire [15:0] half_bit = {1'b0, baud_ff[15:1]};

  // The strap is caught one cycle after the hardware reset releases.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rst_seen_ff <= 1'b1;
      mode_ff     <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b0;
      if (sw_reset_in) begin
        mode_ff <= 1'b0;
      end else if (rst_seen_ff) begin
        mode_ff <= ~strap_ff;
      end
    end
  end

  // Byte FIFO between receiver and memory writer; the writer drains one per cycle.
  logic [7:0] fifo_data;
  logic       fifo_valid, fifo_wready;
  wire        fifo_rready = (state_ff == ST_LOAD) || (state_ff == ST_RUN);
  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_data_in   (rx_data_ff),
    .wr_valid_in  (rx_done_ff),
    .wr_ready_out (fifo_wready),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_rready)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:       if (rst_seen_ff == 1'b0 && mode_ff) nxt_state = ST_INIT;
      ST_INIT:       if (cnt_zero) nxt_state = ST_WAIT_START;
      ST_WAIT_START: if (rx_fall) nxt_state = ST_MEASURE;
      ST_MEASURE:    if (rx_rise) nxt_state = ST_TX_DELAY;
      ST_TX_DELAY:   if (cnt_zero) nxt_state = ST_SEND_ACK;
      ST_SEND_ACK:   if (bit_tick && bit_idx_ff == 4'd9) nxt_state = ST_LOAD;
      ST_LOAD:       if (wr_idx_ff == `IDX_W'(`CODE_BYTES - 1) && fifo_valid) begin
        nxt_state = ST_RUN;
      end
      ST_RUN:        nxt_state = ST_RUN;
      default:       nxt_state = ST_IDLE;
    endcase
    if (!mode_ff) nxt_state = ST_IDLE;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      baud_ff  <= 16'h0001;
      oe_ff    <= 1'b0;
      tx_ff    <= 1'b1;
      bit_cnt_ff <= '0;
      bit_idx_ff <= '0;
      shift_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= `CNT_W'(INIT_CYCLES);
          oe_ff  <= 1'b0;
        end
        ST_INIT: cnt_ff <= cnt_ff - 1'b1;
        ST_WAIT_START: cnt_ff <= '0;
        ST_MEASURE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (rx_rise) begin
            // Nine bit times divided by nine gives clocks per bit.
            baud_ff <= 16'((cnt_ff + `CNT_W'(`ZERO_BYTE_BITS / 2)) / `ZERO_BYTE_BITS);
            cnt_ff  <= `CNT_W'(TX_DELAY_CYCLES);
          end
        end
        ST_TX_DELAY: begin
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_zero) begin
            oe_ff      <= 1'b1;
            shift_ff   <= {1'b1, `ACK_BYTE_VALUE, 1'b0};
            bit_idx_ff <= '0;
            bit_cnt_ff <= baud_ff - 1'b1;
            tx_ff      <= 1'b0;
          end
        end
        ST_SEND_ACK: begin
          if (bit_tick) begin
            bit_cnt_ff <= baud_ff - 1'b1;
            bit_idx_ff <= bit_idx_ff + 1'b1;
            shift_ff   <= {1'b1, shift_ff[9:1]};
            tx_ff      <= (bit_idx_ff == 4'd9) ? 1'b1 : shift_ff[1];
          end else begin
            bit_cnt_ff <= bit_cnt_ff - 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Receiver for the code bytes, at the derived baud factor.
  logic [15:0] rx_cnt_ff;
  logic [3:0]  rx_bit_ff;
  logic [7:0]  rx_sh_ff;
  wire rx_enable = (state_ff == ST_LOAD) && (rx_count_ff != (`IDX_W+1)'(`CODE_BYTES));
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_busy_ff  <= 1'b0;
      rx_cnt_ff   <= '0;
      rx_bit_ff   <= '0;
      rx_sh_ff    <= '0;
      rx_data_ff  <= '0;
      rx_done_ff  <= 1'b0;
      rx_count_ff <= '0;
    end else begin
      rx_done_ff <= 1'b0;
      if (!rx_busy_ff) begin
        if (rx_enable && rx_fall) begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff  <= half_bit + baud_ff;
          rx_bit_ff  <= '0;
        end
      end else if (rx_cnt_ff == '0) begin
        rx_cnt_ff <= baud_ff - 1'b1;
        rx_bit_ff <= rx_bit_ff + 1'b1;
        if (rx_bit_ff == 4'd8) begin
          rx_busy_ff <= 1'b0;
          // A byte that finds the FIFO full is dropped; the writer drains faster than a frame.
          rx_done_ff  <= fifo_wready;
          rx_data_ff  <= rx_sh_ff;
          rx_count_ff <= rx_count_ff + 1'b1;
        end else begin
          rx_sh_ff <= {rx_ff, rx_sh_ff[7:1]};
        end
      end else begin
        rx_cnt_ff <= rx_cnt_ff - 1'b1;
      end
    end
  end

  // Memory writer: bytes land in order from the load base; the branch fires with the last write.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_idx_ff   <= '0;
      mem_wr_ff   <= '0;
      mem_wr_v_ff <= 1'b0;
      branch_ff   <= 1'b0;
    end else begin
      mem_wr_v_ff <= 1'b0;
      branch_ff   <= 1'b0;
      if (state_ff == ST_LOAD && fifo_valid) begin
        mem_wr_ff.addr <= `LOAD_BASE_ADDR + {19'h00000, wr_idx_ff};
        mem_wr_ff.data <= fifo_data;
        mem_wr_v_ff    <= 1'b1;
        wr_idx_ff      <= wr_idx_ff + 1'b1;
      end
      if (state_ff == ST_LOAD && nxt_state == ST_RUN) begin
        branch_ff <= 1'b1;
      end
    end
  end

  assign serial_transmit_line_out  = tx_ff;
  assign serial_transmit_oe_out    = oe_ff;
  assign bootstrap_loader_mode_out = mode_ff;
  assign baud_factor_out           = baud_ff;
  assign mem_write_out             = mem_wr_ff;
  assign mem_write_valid_out       = mem_wr_v_ff;
  assign branch_out                = branch_ff;
  assign branch_addr_out           = `LOAD_BASE_ADDR;
endmodule
`default_nettype wire

/* File: tb/boot_loader_asserts.sv */
// Port-level assertions for the serial bootstrap loader.
`timescale 1ns/1ps
`default_nettype none
module boot_loader_asserts
  import boot_loader_pkg::*;
#(
  parameter int TX_DELAY_CYCLES = 60
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        sw_reset_in,
  input wire logic        boot_strap_pin_in,
  input wire logic        serial_receive_line_in,
  input wire logic        serial_transmit_line_out,
  input wire logic        serial_transmit_oe_out,
  input wire logic        bootstrap_loader_mode_out,
  input wire load_write_t mem_write_out,
  input wire logic        mem_write_valid_out,
  input wire logic        branch_out,
  input wire logic [23:0] branch_addr_out
);
  int hi_cnt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Counts how long the receive line has stayed high, so the pin delay can be judged.
  always_ff @(posedge clk_in) hi_cnt <= serial_receive_line_in ? hi_cnt + 1 : 0;
  property p_mode_entry;
    $fell(sys_rst_in) |-> !bootstrap_loader_mode_out
      ##1 bootstrap_loader_mode_out == !boot_strap_pin_in;
  endproperty
  a_mode_entry: assert property (p_mode_entry) else $error("mode entry wrong");
  property p_sw_exit;
    sw_reset_in |=> !bootstrap_loader_mode_out;
  endproperty
  a_sw_exit: assert property (p_sw_exit) else $error("mode kept on sw reset");
  property p_tx_quiet;
    !serial_transmit_oe_out |-> serial_transmit_line_out;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("tx not idle");
  property p_oe_keeps;
    serial_transmit_oe_out && bootstrap_loader_mode_out && !sw_reset_in
      |=> serial_transmit_oe_out;
  endproperty
  a_oe_keeps: assert property (p_oe_keeps) else $error("oe dropped");
  property p_oe_delay;
    $rose(serial_transmit_oe_out) |-> hi_cnt >= TX_DELAY_CYCLES;
  endproperty
  a_oe_delay: assert property (p_oe_delay) else $error("oe too early");
  property p_write_range;
    mem_write_valid_out |-> mem_write_out.addr inside {[24'h00fa40:24'h00fa5f]};
  endproperty
  a_write_range: assert property (p_write_range) else $error("bad store addr");
  property p_branch_last;
    branch_out |-> mem_write_valid_out && mem_write_out.addr == 24'h00fa5f
      && branch_addr_out == 24'h00fa40 && bootstrap_loader_mode_out;
  endproperty
  a_branch_last: assert property (p_branch_last) else $error("bad branch");
  property p_branch_once;
    branch_out |=> !branch_out [*3];
  endproperty
  a_branch_once: assert property (p_branch_once) else $error("branch repeats");
  c_oe: cover property ($rose(serial_transmit_oe_out));
  c_branch: cover property (branch_out);
  c_sw: cover property (sw_reset_in && bootstrap_loader_mode_out);
endmodule
bind boot_loader boot_loader_asserts #(.TX_DELAY_CYCLES(TX_DELAY_CYCLES)) u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sw_reset_in(sw_reset_in),
  .boot_strap_pin_in(boot_strap_pin_in), .serial_receive_line_in(serial_receive_line_in),
  .serial_transmit_line_out(serial_transmit_line_out),
  .serial_transmit_oe_out(serial_transmit_oe_out),
  .bootstrap_loader_mode_out(bootstrap_loader_mode_out), .mem_write_out(mem_write_out),
  .mem_write_valid_out(mem_write_valid_out), .branch_out(branch_out),
  .branch_addr_out(branch_addr_out));
`default_nettype wire

/* File: tb/boot_host_model.sv */
// Serial host: zero byte, wait for the acknowledge, then the code bytes.
`timescale 1ns/1ps
`default_nettype none
module boot_host_model #(
  parameter int BIT = 12
) (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic tx_line_in,
  output logic      rx_line_out
);
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line_out <= f[i];
      repeat (BIT) @(posedge clk_in);
    end
  endtask
  initial begin
    rx_line_out = 1'b1;
    @(posedge clk_in iff go_in);
    send(8'h00);
    @(posedge clk_in iff !tx_line_in);
    repeat (BIT * 12) @(posedge clk_in);
    for (int i = 0; i < 32; i++) send(8'h5a ^ 8'(i));
  end
endmodule
`default_nettype wire

/* File: tb/test_boot_loader.sv */
// Self-checking bench for the serial bootstrap loader.
`timescale 1ns/1ps
`default_nettype none
`include "boot_loader_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_boot_loader;
  import boot_loader_pkg::*;
  localparam int BIT = 12;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        sw_rst = 1'b0;
  logic        strap = 1'b0;
  logic        go = 1'b0;
  logic        rx, tx, oe, mode, wv, br;
  logic [15:0] baud;
  logic [23:0] baddr;
  logic [7:0]  ack;
  load_write_t wr;
  load_write_t rows [32];
  wire         tx_wire;
  int          n_errors = 0;
  int          num_checks = 0;
  int          k;
  // The transmit pin has a pull-up, so an undriven pin reads high.
  assign tx_wire = oe ? tx : 1'b1;
  always #4 clk_in = ~clk_in;
  boot_loader #(.INIT_CYCLES(50), .TX_DELAY_CYCLES(60)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sw_reset_in(sw_rst),
    .boot_strap_pin_in(strap), .serial_receive_line_in(rx), .serial_transmit_line_out(tx),
    .serial_transmit_oe_out(oe), .bootstrap_loader_mode_out(mode), .baud_factor_out(baud),
    .mem_write_out(wr), .mem_write_valid_out(wv), .branch_out(br), .branch_addr_out(baddr));
  boot_host_model #(.BIT(BIT)) u_host (
    .clk_in(clk_in), .go_in(go), .tx_line_in(tx_wire), .rx_line_out(rx));
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hw_reset(input logic s);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    strap <= s;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  initial begin
    for (int i = 0; i < 32; i++) rows[i] = '{24'h00fa40 + 24'(i), 8'h5a ^ 8'(i)};
    repeat (6) @(posedge clk_in);
    #1 `CHK({oe, tx, mode, wv, br}, 5'b01000)
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 `CHK(mode, 1'b1)
    repeat (60) @(posedge clk_in);
    go <= 1'b1;
    repeat (10 * BIT) @(posedge clk_in);
    #1 `CHK(baud, 16'(BIT))
    `CHK(oe, 1'b0)
    for (k = 0; k < 300 && tx_wire; k++) begin @(posedge clk_in); #1; end
    `CHK(oe, 1'b1)
    repeat (BIT / 2) @(posedge clk_in);
    for (int b = 0; b < 8; b++) begin
      repeat (BIT) @(posedge clk_in);
      #1 ack[b] = tx_wire;
    end
    `CHK(ack, `ACK_BYTE_VALUE)
    foreach (rows[i]) begin
      for (k = 0; k < 400 && wv !== 1'b1; k++) begin @(posedge clk_in); #1; end
      `CHK(wr, rows[i])
      `CHK(br, (i == 31))
      @(posedge clk_in);
      #1;
    end
    `CHK({baddr, mode}, {24'h00fa40, 1'b1})
    @(posedge clk_in);
    sw_rst <= 1'b1;
    @(posedge clk_in);
    sw_rst <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 `CHK(mode, 1'b0)
    hw_reset(1'b1);
    `CHK(mode, 1'b0)
    hw_reset(1'b0);
    `CHK(mode, 1'b1)
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
